/* core/pcd_ctrl.sv */
// Top of the enable and dimming controller with pump mode sequencing.
`timescale 1ns/1ps
module pcd_ctrl #(
  parameter int unsigned SHDN_CYCLES   = pcd_pkg::SHDN_CYCLES,
  parameter int unsigned FILTER_CYCLES = pcd_pkg::FILTER_CYCLES
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Single wire enable and dimming pin
  input  wire logic       ENABLE_DIM_INPUT,
  // Analog monitors
  input  wire logic       UNDERVOLTAGE,
  input  wire logic       PUMP_OVERVOLTAGE,
  input  wire logic       REGULATION_FAIL,
  input  wire logic       UNITY_SUPPLY_OK,
  // Drive outputs
  output logic            DEVICE_ENABLED,
  output logic [4:0]      CURRENT_LEVEL,
  output logic [2:0]      LED_SINK_EN,
  output logic            CURRENT_SET_PIN_EN,
  output logic [1:0]      PUMP_GAIN
);

  // Pin and monitor levels, in the bit order of the assignment below.
  logic [4:0] raw_in;
  logic [4:0] sync_in;
  logic       en_prev;
  logic       low_seen;
  logic       enabled;
  logic [4:0] pulses;

  assign raw_in = {UNITY_SUPPLY_OK, REGULATION_FAIL, PUMP_OVERVOLTAGE,
                   UNDERVOLTAGE, ENABLE_DIM_INPUT};

  // Two flops on every asynchronous input; only the second one is read.
  for (genvar i = 0; i < 5; i++) begin : g_sync
    logic [1:0] stage;
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        stage <= 2'h0;
      end else begin
        stage <= {stage[0], raw_in[i]};
      end
    end
    assign sync_in[i] = stage[1];
  end

  wire en_lvl     = sync_in[0];
  wire undervolt  = sync_in[1];
  wire overvolt   = sync_in[2];
  wire reg_fail   = sync_in[3];
  wire unity_ok   = sync_in[4];
  wire rise       = en_lvl && !en_prev;
  wire low_now    = !en_lvl;
  logic shdn_done;
  logic low_valid;

  // Long-low timeout; every low while enabled counts toward it from its first cycle.
  // Expiry shows one cycle after the count, so the limit is one short and
  // a low of exactly the shutdown time still shuts the device down.
  pcd_timer #(.LIMIT(SHDN_CYCLES - 1)) u_shdn (
    .clk  (CLK),
    .rst  (RST),
    .run  (low_now && enabled),
    .done (shdn_done)
  );

  // Low phases shorter than the minimum are glitches and do not count.
  // The limit is one short so that a low of exactly the minimum counts.
  pcd_timer #(.LIMIT(pcd_pkg::MIN_LOW_CYCLES - 1)) u_glitch (
    .clk  (CLK),
    .rst  (RST),
    .run  (low_now),
    .done (low_valid)
  );

  wire go_shutdown = enabled && (shdn_done || undervolt);
  wire wake        = !enabled && rise && !undervolt;
  wire step        = enabled && rise && low_seen;

  // Count 31 is zero current; one more wraps to full scale.
  wire [4:0] next_pulses = (pulses == 5'(pcd_pkg::MAX_COUNT)) ?
                           pcd_pkg::COUNT_RESET : pulses + 5'h01;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      en_prev  <= 1'b0;
      low_seen <= 1'b0;
      enabled  <= 1'b0;
      pulses   <= 5'h00;
    end else begin
      en_prev <= en_lvl;
      if (low_valid) begin
        low_seen <= 1'b1;
      end else if (rise) begin
        low_seen <= 1'b0;
      end
      if (go_shutdown) begin
        enabled <= 1'b0;
        pulses  <= pcd_pkg::COUNT_RESET;
      end else if (wake) begin
        enabled <= 1'b1;
        pulses  <= pcd_pkg::COUNT_RESET;
      end else if (step) begin
        pulses  <= next_pulses;
      end
    end
  end

  pcd_pkg::pcd_gain_e gain;

  // Shutdown and overvoltage both restart the mode sequence from 1x.
  pcd_gain #(.FILTER(FILTER_CYCLES)) u_gain (
    .clk      (CLK),
    .rst      (RST),
    .restart  (overvolt || !enabled || go_shutdown),
    .reg_fail (reg_fail),
    .unity_ok (unity_ok),
    .gain     (gain)
  );

  // Level is the dimming numerator 31 minus count.
  wire [4:0] level = 5'(pcd_pkg::MAX_COUNT) - pulses;

  // Enable and level travel together into the output flops.
  pcd_pkg::pcd_drive_s drive;
  assign drive = '{enabled: enabled, level: enabled ? level : 5'h00};

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      DEVICE_ENABLED     <= 1'b0;
      CURRENT_LEVEL      <= 5'h00;
      LED_SINK_EN        <= 3'h0;
      CURRENT_SET_PIN_EN <= 1'b0;
      PUMP_GAIN          <= 2'h0;
    end else begin
      DEVICE_ENABLED     <= drive.enabled;
      CURRENT_LEVEL      <= drive.level;
      LED_SINK_EN        <= {3{drive.enabled}};
      CURRENT_SET_PIN_EN <= drive.enabled;
      PUMP_GAIN          <= gain;
    end
  end

endmodule : pcd_ctrl

/* inc/pcd_pkg.sv */
// Package of constants and types for the pulse count dimming controller.
// Summary of operation
// - First high while shut down enables at full scale, count zero.
// - Input held low 1.5 ms or longer puts the device into shutdown.
// - Each rising edge after a valid low while enabled advances the pulse count by one.
// - Count 30 gives one step, 31 gives zero, next pulse wraps to full.
// - Current level equals full scale times (31 minus count) over 31.
// - Low pulses shorter than minimum program low time are rejected.
// - Low phase beyond maximum program low time runs the shutdown timer; here it runs from the start of every low while enabled.
// - Pump mode starts in 1x and stays while regulation holds.
// - Regulation failure for 120 us steps gain 1x, 1.33x, 1.5x, 2x.
// - Step down only straight back to 1x when supply suffices.
// - Undervoltage disables all channels and enters shutdown.
// - Shutdown makes every sink and the set pin high impedance.
// - Pump output overvoltage resets the mode controller to 1x.
package pcd_pkg;

  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned SHDN_TIME_US   = 1500;
  localparam int unsigned FILTER_TIME_US = 120;
  localparam int unsigned MIN_LOW_NS     = 200;
  localparam int unsigned SHDN_CYCLES    = SHDN_TIME_US * CLK_MHZ;
  localparam int unsigned FILTER_CYCLES  = FILTER_TIME_US * CLK_MHZ;
  localparam int unsigned MIN_LOW_CYCLES = (MIN_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MAX_COUNT      = 31;
  localparam logic [4:0]  COUNT_RESET    = 5'h00;
  localparam int unsigned LEVEL_W        = 5;
  localparam int unsigned NUM_SINKS      = 3;

  typedef enum logic [1:0] {
    PCD_GAIN_1X,
    PCD_GAIN_133X,
    PCD_GAIN_15X,
    PCD_GAIN_2X
  } pcd_gain_e;

  typedef struct packed {
    logic enabled;
    logic [4:0] level;
  } pcd_drive_s;

endpackage : pcd_pkg

/* core/pcd_timer.sv */
// Saturating timer that counts while its condition holds.
`timescale 1ns/1ps
module pcd_timer #(
  parameter int unsigned LIMIT = 16
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Condition and expiry
  input  wire logic run,
  output logic      done
);

  localparam int unsigned W = $clog2(LIMIT + 1);
  logic [W-1:0] count;
  wire          at_limit = (count == W'(LIMIT));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (!run) begin
      count <= '0;
    end else if (!at_limit) begin
      count <= count + W'(1);
    end
  end

  assign done = run && at_limit;

endmodule : pcd_timer

/* core/pcd_gain.sv */
// Charge pump gain sequencer.
`timescale 1ns/1ps
module pcd_gain #(
  parameter int unsigned FILTER = 15000
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Conditions
  input  wire logic              restart,
  input  wire logic              reg_fail,
  input  wire logic              unity_ok,
  // Mode
  output pcd_pkg::pcd_gain_e     gain
);

  logic wait_done;
  logic stepped;
  wire  can_step = (gain != pcd_pkg::PCD_GAIN_2X);

  // The filter restarts after every step, so each higher gain waits anew
  // instead of racing through all modes once the count has saturated.
  pcd_timer #(.LIMIT(FILTER)) u_filter (
    .clk  (clk),
    .rst  (rst),
    .run  (reg_fail && can_step && !restart && !stepped),
    .done (wait_done)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gain    <= pcd_pkg::PCD_GAIN_1X;
      stepped <= 1'b0;
    end else begin
      stepped <= wait_done;
      if (restart) begin
        gain <= pcd_pkg::PCD_GAIN_1X;
      end else if (unity_ok && !reg_fail) begin
        gain <= pcd_pkg::PCD_GAIN_1X;
      end else if (wait_done) begin
        gain <= pcd_pkg::pcd_gain_e'(gain + 2'h1);
      end
    end
  end

endmodule : pcd_gain

/* test/pcd_ctrl_props.sv */
// Checker that ties the controller outputs to their causes.
`timescale 1ns/1ps
module pcd_ctrl_props #(
  parameter int unsigned SHDN_CYCLES   = 200,
  parameter int unsigned FILTER_CYCLES = 50
) (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RST,
  // Pin and monitors
  input wire logic       ENABLE_DIM_INPUT,
  input wire logic       UNDERVOLTAGE,
  input wire logic       PUMP_OVERVOLTAGE,
  input wire logic       REGULATION_FAIL,
  input wire logic       UNITY_SUPPLY_OK,
  // Drive outputs
  input wire logic       DEVICE_ENABLED,
  input wire logic [4:0] CURRENT_LEVEL,
  input wire logic [2:0] LED_SINK_EN,
  input wire logic       CURRENT_SET_PIN_EN,
  input wire logic [1:0] PUMP_GAIN
);
  int fail_run;
  int low_run;
  default clocking dc @(posedge CLK); endclocking
  default disable iff (RST);
  // Counting the raw inputs is safe, as the sync delay only adds to them.
  always_ff @(posedge CLK or posedge RST)
    if (RST) fail_run <= 0;
    else fail_run <= REGULATION_FAIL ? fail_run + 1 : 0;
  always_ff @(posedge CLK or posedge RST)
    if (RST) low_run <= 0;
    else low_run <= ENABLE_DIM_INPUT ? 0 : low_run + 1;
  sequence s_up;
    $changed(PUMP_GAIN) && PUMP_GAIN != 2'h0;
  endsequence
  AST_SINKS: assert property (LED_SINK_EN == {3{DEVICE_ENABLED}})
    else $error("sinks disagree with enable");
  AST_SETPIN: assert property (CURRENT_SET_PIN_EN == DEVICE_ENABLED)
    else $error("set pin disagrees with enable");
  AST_WAKE: assert property ($rose(DEVICE_ENABLED) |->
    CURRENT_LEVEL == 5'h1f) else $error("wake not at full scale");
  AST_OFF: assert property (!DEVICE_ENABLED |->
    CURRENT_LEVEL == 5'h00 && PUMP_GAIN == 2'h0) else $error("off not clear");
  AST_STEP: assert property (
    DEVICE_ENABLED && $past(DEVICE_ENABLED) && $changed(CURRENT_LEVEL) |->
    CURRENT_LEVEL == $past(CURRENT_LEVEL) - 5'h01)
    else $error("level step wrong");
  AST_UV: assert property (UNDERVOLTAGE[*6] |-> !DEVICE_ENABLED)
    else $error("enabled under low supply");
  AST_OV: assert property (
    PUMP_OVERVOLTAGE[*5] |-> PUMP_GAIN == 2'h0)
    else $error("gain not reset");
  AST_UP: assert property (s_up |->
    PUMP_GAIN == $past(PUMP_GAIN) + 2'h1 && fail_run >= FILTER_CYCLES)
    else $error("gain step wrong");
  AST_UNITY: assert property (
    (UNITY_SUPPLY_OK && !REGULATION_FAIL)[*6] |-> PUMP_GAIN == 2'h0)
    else $error("gain not back to unity");
  // A long low must end in shutdown once sync and output delays have passed.
  AST_SHDN: assert property (
    low_run >= SHDN_CYCLES + 4 |-> !DEVICE_ENABLED)
    else $error("no shutdown after long low");
endmodule : pcd_ctrl_props
bind pcd_ctrl pcd_ctrl_props #(
  .SHDN_CYCLES   (SHDN_CYCLES),
  .FILTER_CYCLES (FILTER_CYCLES)
) u_props (
  .CLK                (CLK),
  .RST                (RST),
  .ENABLE_DIM_INPUT   (ENABLE_DIM_INPUT),
  .UNDERVOLTAGE       (UNDERVOLTAGE),
  .PUMP_OVERVOLTAGE   (PUMP_OVERVOLTAGE),
  .REGULATION_FAIL    (REGULATION_FAIL),
  .UNITY_SUPPLY_OK    (UNITY_SUPPLY_OK),
  .DEVICE_ENABLED     (DEVICE_ENABLED),
  .CURRENT_LEVEL      (CURRENT_LEVEL),
  .LED_SINK_EN        (LED_SINK_EN),
  .CURRENT_SET_PIN_EN (CURRENT_SET_PIN_EN),
  .PUMP_GAIN          (PUMP_GAIN)
);

/* test/pcd_host.sv */
// Host model that drives the single enable and dimming wire.
`timescale 1ns/1ps
module pcd_host (
  // Clock
  input wire logic clk,
  // Wire toward the device
  output logic     pin
);
  initial pin = 1'b0;
  task automatic hold(input logic v, input int n);
    pin = v;
    repeat (n) @(negedge clk);
  endtask : hold
  // The high phase is long enough to be seen; a rise counts only if its low reached the minimum.
  task automatic pulse(input int lo);
    hold(1'b0, lo);
    hold(1'b1, 30);
  endtask : pulse
endmodule : pcd_host

/* test/tb.sv */
// Self-checking bench for the dimming and pump mode controller.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst = 1'b1, uv = 1'b0, ov = 1'b0, fail = 1'b0;
  logic unity = 1'b0;
  logic pin;
  wire [11:0] outs;
  int num_errors = 0, checks_done = 0, seed = 32'h3803, n = 0, k;
  always #4 clk = ~clk;
  pcd_host host (.clk(clk), .pin(pin));
  pcd_ctrl #(.SHDN_CYCLES(200), .FILTER_CYCLES(50)) DUT (.CLK(clk),
    .RST(rst), .ENABLE_DIM_INPUT(pin), .UNDERVOLTAGE(uv),
    .PUMP_OVERVOLTAGE(ov), .REGULATION_FAIL(fail), .UNITY_SUPPLY_OK(unity),
    .DEVICE_ENABLED(outs[11]), .CURRENT_LEVEL(outs[10:6]),
    .LED_SINK_EN(outs[5:3]), .CURRENT_SET_PIN_EN(outs[2]),
    .PUMP_GAIN(outs[1:0]));
  function automatic logic [11:0] st(logic e, int c, logic [1:0] g);
    return {e, e ? 5'(31 - c % 32) : 5'h00, {3{e}}, e, g};
  endfunction : st
  task automatic chk(logic [11:0] exp);
    checks_done++;
    if (outs !== exp) begin
      num_errors++;
      $display("Error %0t: outputs %h, expected %h", $time, outs, exp);
    end
  endtask : chk
  task automatic wt(int c);
    repeat (c) @(negedge clk);
  endtask : wt
  task automatic end_sim;
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
  initial begin
    wt(3);
    rst = 1'b0;
    chk(st(0, 0, 2'h0));
    host.hold(1'b1, 8);
    chk(st(1, 0, 2'h0));
    for (int i = 0; i < 8; i++) begin
      k = i == 0 ? 30 : i < 3 ? 1 : 1 + $unsigned($random(seed)) % 12;
      repeat (k) host.pulse(25 + $unsigned($random(seed)) % 20);
      n += k;
      chk(st(1, n, 2'h0));
    end
    host.pulse(24);
    chk(st(1, n, 2'h0));
    repeat (6) begin
      fail = 1'b1;
      wt(1 + $unsigned($random(seed)) % 40);
      fail = 1'b0;
      wt(2);
    end
    chk(st(1, n, 2'h0));
    fail = 1'b1;
    for (int g = 1; g < 5; g++) begin
      wt(60);
      chk(st(1, n, 2'(g > 3 ? 3 : g)));
    end
    fail = 1'b0;
    unity = 1'b1;
    wt(8);
    chk(st(1, n, 2'h0));
    unity = 1'b0;
    fail = 1'b1;
    wt(60);
    ov = 1'b1;
    fail = 1'b0;
    wt(8);
    chk(st(1, n, 2'h0));
    ov = 1'b0;
    fail = 1'b1;
    wt(60);
    fail = 1'b0;
    host.hold(1'b0, 150);
    chk(st(1, n, 2'h1));
    host.hold(1'b1, 10);
    n++;
    chk(st(1, n, 2'h1));
    host.hold(1'b0, 210);
    chk(st(0, 0, 2'h0));
    host.hold(1'b1, 8);
    chk(st(1, 0, 2'h0));
    uv = 1'b1;
    wt(6);
    chk(st(0, 0, 2'h0));
    host.pulse(30);
    chk(st(0, 0, 2'h0));
    uv = 1'b0;
    host.pulse(30);
    chk(st(1, 0, 2'h0));
    end_sim();
  end
endmodule : tb
